/* flm_consts.vh */
// constants for the fault limit monitor: command codes, reset codes, field layout
// assumes a same-clock command transport that decodes bus transfers into strobes
`ifndef FLM_CONSTS_VH
`define FLM_CONSTS_VH

// command codes of the three thresholds
`define FLM_CMD_PEAK_OC 8'h46
`define FLM_CMD_VALLEY_UC 8'h4B
`define FLM_CMD_OVER_TEMP 8'h4F

// power-on codes
`define FLM_RST_PEAK_OC 16'hDBC0
`define FLM_RST_VALLEY_UC 16'hD440
`define FLM_RST_OVER_TEMP 16'hEBE8

// linear word layout: exponent above, mantissa below
`define FLM_EXP_MSB 15
`define FLM_EXP_LSB 11
`define FLM_MANT_MSB 10
`define FLM_MANT_LSB 0

// measurements are signed with this many fraction bits
`define FLM_FRAC_BITS 4

`endif

/* flm_fault_check_monitor.sv */
// concurrent checks on the ports of the fault limit monitor
// assumes one clock domain, clk, with rst_n as its only reset
`timescale 1ns/10ps
module flm_fault_check (
  input wire clk,
  input wire rst_n,
  input wire cmd_rd,
  input wire clear_faults,
  input wire period_start,
  input wire avg_oc_fault,
  input wire avg_uc_fault,
  input wire temp_valid,
  input wire rd_valid_ff,
  input wire overcurrent_flag_ff,
  input wire undercurrent_flag_ff,
  input wire oc_response_ff,
  input wire uc_response_ff,
  input wire temperature_summary_ff,
  input wire over_temp_flag_ff,
  input wire external_sensor_a_fault_flag_ff,
  input wire host_alert_line_n_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_read_answer: assert property (cmd_rd |=> rd_valid_ff) else $error("read unanswered");
  a_oc_sticky: assert property (overcurrent_flag_ff && !clear_faults |=> overcurrent_flag_ff)
    else $error("oc flag dropped");
  a_ot_sticky: assert property (over_temp_flag_ff && !clear_faults |=> over_temp_flag_ff)
    else $error("ot flag dropped");
  a_summary_pair: assert property (temperature_summary_ff == over_temp_flag_ff)
    else $error("summary differs");
  a_sensor_pair: assert property ($rose(external_sensor_a_fault_flag_ff) |-> over_temp_flag_ff)
    else $error("sensor flag alone");
  a_alert_pending: assert property (over_temp_flag_ff || overcurrent_flag_ff
    || undercurrent_flag_ff |-> !host_alert_line_n_ff) else $error("alert idle");
  a_avg_oc: assert property (avg_oc_fault |=> oc_response_ff && overcurrent_flag_ff)
    else $error("avg oc lost");
  a_avg_uc: assert property (avg_uc_fault |=> uc_response_ff && undercurrent_flag_ff)
    else $error("avg uc lost");
  a_oc_cause: assert property ($rose(overcurrent_flag_ff)
    |-> $past(period_start) || $past(avg_oc_fault)) else $error("oc off boundary");
  a_clear_flags: assert property (clear_faults && !period_start && !avg_oc_fault
    && !avg_uc_fault && !temp_valid |=> !overcurrent_flag_ff && !over_temp_flag_ff)
    else $error("flags not cleared");
endmodule
bind flm_fault_limit_monitor flm_fault_check i_flm_fault_check (.clk, .rst_n, .cmd_rd,
  .clear_faults, .period_start, .avg_oc_fault, .avg_uc_fault, .temp_valid, .rd_valid_ff,
  .overcurrent_flag_ff, .undercurrent_flag_ff, .oc_response_ff, .uc_response_ff,
  .temperature_summary_ff, .over_temp_flag_ff, .external_sensor_a_fault_flag_ff,
  .host_alert_line_n_ff);

/* flm_fault_limit_monitor.v */
// fault limit monitor: peak, valley and over-temperature checks of a two-phase controller
// assumes measurement strobes and the command port run on clk; only rst_n is asynchronous
`timescale 1ns/10ps
`include "flm_consts.vh"

module flm_fault_limit_monitor #(
  parameter MW = 16,
  parameter CW = 8
) (
  input wire clk,
  input wire rst_n,
  input wire cmd_wr,
  input wire cmd_rd,
  input wire [7:0] cmd_code,
  input wire [15:0] cmd_wdata,
  input wire write_protect,
  input wire clear_faults,
  input wire period_start,
  input wire [CW-1:0] blank_cycles,
  input wire [CW-1:0] consec_periods,
  input wire cur_valid,
  input wire signed [MW-1:0] phase0_current,
  input wire signed [MW-1:0] phase1_current,
  input wire avg_oc_fault,
  input wire avg_uc_fault,
  input wire external_temperature_sensing,
  input wire temp_valid,
  input wire signed [MW-1:0] internal_temp,
  input wire signed [MW-1:0] ext_temp_a,
  input wire signed [MW-1:0] ext_temp_b,
  output reg [15:0] rd_data_ff,
  output reg rd_valid_ff,
  output reg overcurrent_flag_ff,
  output reg undercurrent_flag_ff,
  output reg oc_response_ff,
  output reg uc_response_ff,
  output reg temperature_summary_ff,
  output reg over_temp_flag_ff,
  output reg internal_sensor_fault_flag_ff,
  output reg external_sensor_a_fault_flag_ff,
  output reg external_sensor_b_fault_flag_ff,
  output reg host_alert_line_n_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // linear word to signed fixed point; wide enough for any exponent
  function signed [47:0] lin_to_fix;
    input [15:0] word;
    reg signed [5:0] sh;
    reg signed [47:0] m;
    begin
      sh = $signed({word[`FLM_EXP_MSB], word[`FLM_EXP_MSB:`FLM_EXP_LSB]}) + 6'sd`FLM_FRAC_BITS;
      m = {{37{word[`FLM_MANT_MSB]}}, word[`FLM_MANT_MSB:`FLM_MANT_LSB]};
      if (sh[5]) begin
        lin_to_fix = m >>> (-sh);
      end else begin
        lin_to_fix = m <<< sh;
      end
    end
  endfunction

  // sign extension of a measurement to compare width
  function signed [47:0] ext_meas;
    input signed [MW-1:0] v;
    begin
      ext_meas = {{(48-MW){v[MW-1]}}, v};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops

  reg rst_meta_ff;
  reg rst_sync_ff; // design-wide reset copy
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // threshold registers

  reg [15:0] peak_current_fault_threshold_ff;
  reg [15:0] valley_current_fault_threshold_ff;
  reg [15:0] over_temp_fault_threshold_ff;

  // writes take the whole two-byte word; protection drops them silently
  always @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      peak_current_fault_threshold_ff <= `FLM_RST_PEAK_OC;
      valley_current_fault_threshold_ff <= `FLM_RST_VALLEY_UC;
      over_temp_fault_threshold_ff <= `FLM_RST_OVER_TEMP;
    end else if (cmd_wr && !write_protect) begin
      case (cmd_code)
        `FLM_CMD_PEAK_OC: peak_current_fault_threshold_ff <= cmd_wdata;
        `FLM_CMD_VALLEY_UC: valley_current_fault_threshold_ff <= cmd_wdata;
        `FLM_CMD_OVER_TEMP: over_temp_fault_threshold_ff <= cmd_wdata;
        default: ;
      endcase
    end
  end

  // read answer one cycle after the strobe; unknown codes read zero
  always @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rd_data_ff <= 16'h0000;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= cmd_rd;
      if (cmd_rd) begin
        case (cmd_code)
          `FLM_CMD_PEAK_OC: rd_data_ff <= peak_current_fault_threshold_ff;
          `FLM_CMD_VALLEY_UC: rd_data_ff <= valley_current_fault_threshold_ff;
          `FLM_CMD_OVER_TEMP: rd_data_ff <= over_temp_fault_threshold_ff;
          default: rd_data_ff <= 16'h0000;
        endcase
      end
    end
  end

  // decoded thresholds; the host keeps them in range so no saturation is done
  wire signed [47:0] peak_fix = lin_to_fix(peak_current_fault_threshold_ff);
  wire signed [47:0] valley_fix = lin_to_fix(valley_current_fault_threshold_ff);
  wire signed [47:0] temp_fix = lin_to_fix(over_temp_fault_threshold_ff);

  ////////////////////////////////////////////////////////////////////////////
  // blanking within each switching period

  reg [CW-1:0] blank_cnt_ff; // clocks since period start, saturating
  wire blank_done = (blank_cnt_ff >= blank_cycles);
  always @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      blank_cnt_ff <= {CW{1'b0}};
    end else if (period_start) begin
      blank_cnt_ff <= {CW{1'b0}};
    end else if (!blank_done) begin
      blank_cnt_ff <= blank_cnt_ff + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // qualified samples only; samples inside blanking are ignored
  wire qual = cur_valid && blank_done && !period_start;
  wire p0_hi = qual && (ext_meas(phase0_current) > peak_fix);
  wire p1_hi = qual && (ext_meas(phase1_current) > peak_fix);
  wire p0_lo = qual && (ext_meas(phase0_current) < valley_fix);
  wire p1_lo = qual && (ext_meas(phase1_current) < valley_fix);

  ////////////////////////////////////////////////////////////////////////////
  // per-period violation memory and consecutive-period runs, one per phase and check

  reg [3:0] viol_ff; // {p1_lo, p0_lo, p1_hi, p0_hi} seen in current period
  reg [CW-1:0] run_ff [0:3]; // consecutive violating periods
  reg [3:0] trip; // run reached the count at this period boundary
  wire [3:0] hit = {p1_lo, p0_lo, p1_hi, p0_hi};
  // zero count is treated as one period, a fault needs at least one violation
  wire [CW-1:0] need = (consec_periods == {CW{1'b0}}) ? {{(CW-1){1'b0}}, 1'b1} : consec_periods;
  integer i; // loop index of the combinational trip decode
  integer j; // loop index of the clocked run update, apart so each index has one driver

  // run_ff stops counting at need and need is at least one, so need - 1 cannot wrap
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      trip[i] = period_start && viol_ff[i] &&
        (run_ff[i] >= need - {{(CW-1){1'b0}}, 1'b1});
    end
  end

  always @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      viol_ff <= 4'h0;
      for (j = 0; j < 4; j = j + 1) begin
        run_ff[j] <= {CW{1'b0}};
      end
    end else if (period_start) begin
      // a clean period breaks the run
      viol_ff <= 4'h0;
      for (j = 0; j < 4; j = j + 1) begin
        if (!viol_ff[j]) begin
          run_ff[j] <= {CW{1'b0}};
        end else if (run_ff[j] < need) begin
          run_ff[j] <= run_ff[j] + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end else begin
      viol_ff <= viol_ff | hit;
    end
  end

  // either phase alone trips; averaged checks feed the same event
  wire oc_evt = trip[0] || trip[1] || avg_oc_fault;
  wire uc_evt = trip[2] || trip[3] || avg_uc_fault;

  ////////////////////////////////////////////////////////////////////////////
  // temperature check

  wire t_int = temp_valid && !external_temperature_sensing && (ext_meas(internal_temp) > temp_fix);
  wire t_a = temp_valid && external_temperature_sensing &&
    (ext_meas(ext_temp_a) > temp_fix);
  wire t_b = temp_valid && external_temperature_sensing &&
    (ext_meas(ext_temp_b) > temp_fix);
  wire ot_evt = t_int || t_a || t_b;

  ////////////////////////////////////////////////////////////////////////////
  // sticky status; a new event in the clear cycle wins

  always @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      overcurrent_flag_ff <= 1'b0;
      undercurrent_flag_ff <= 1'b0;
      oc_response_ff <= 1'b0;
      uc_response_ff <= 1'b0;
      temperature_summary_ff <= 1'b0;
      over_temp_flag_ff <= 1'b0;
      internal_sensor_fault_flag_ff <= 1'b0;
      external_sensor_a_fault_flag_ff <= 1'b0;
      external_sensor_b_fault_flag_ff <= 1'b0;
      host_alert_line_n_ff <= 1'b1;
    end else begin
      // one-cycle response requests, shared with the averaged checks
      oc_response_ff <= oc_evt;
      uc_response_ff <= uc_evt;
      overcurrent_flag_ff <= oc_evt | (overcurrent_flag_ff & ~clear_faults);
      undercurrent_flag_ff <= uc_evt | (undercurrent_flag_ff & ~clear_faults);
      temperature_summary_ff <= ot_evt | (temperature_summary_ff & ~clear_faults);
      over_temp_flag_ff <= ot_evt | (over_temp_flag_ff & ~clear_faults);
      internal_sensor_fault_flag_ff <= t_int |
        (internal_sensor_fault_flag_ff & ~clear_faults);
      external_sensor_a_fault_flag_ff <= t_a |
        (external_sensor_a_fault_flag_ff & ~clear_faults);
      external_sensor_b_fault_flag_ff <= t_b |
        (external_sensor_b_fault_flag_ff & ~clear_faults);
      // alert held low while any fault is pending or arriving
      host_alert_line_n_ff <= ~(ot_evt | oc_evt | uc_evt |
        ((over_temp_flag_ff | overcurrent_flag_ff | undercurrent_flag_ff) & ~clear_faults));
    end
  end

endmodule

/* flm_host_model.sv */
// host side of the threshold command port, one transfer at a time
// assumes strobes are sampled on the rising edge of clk
`timescale 1ns/10ps
module flm_host_model (
  input wire clk,
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire [15:0] rd_data_ff,
  input wire rd_valid_ff
);
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // whole linear word in one strobe; released lines show the inverse, not the old value
  task wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_wr <= 1'b0;
    cmd_code <= ~c;
    cmd_wdata <= ~d;
  endtask
  // answer is registered, so it is taken once the edge after the strobe has landed
  task rd(input logic [7:0] c, output logic [15:0] d, output logic ok);
    @(posedge clk);
    cmd_rd <= 1'b1;
    cmd_code <= c;
    @(posedge clk);
    cmd_rd <= 1'b0;
    cmd_code <= ~c;
    #1;
    ok = rd_valid_ff;
    d = rd_data_ff;
  endtask
endmodule

/* testbench.sv */
// self-checking bench of the fault limit monitor with a host model on its command port
// assumes power-on thresholds hold until the register writes near the end
`timescale 1ns/10ps
`include "flm_consts.vh"
module testbench;
  logic clk = 1'b0, rst_n = 1'b0, write_protect = 1'b0, clear_faults = 1'b0;
  logic period_start = 1'b0, cur_valid = 1'b0, avg_oc_fault = 1'b0, avg_uc_fault = 1'b0;
  logic ext_on = 1'b0, temp_valid = 1'b0, ok, cmd_wr, cmd_rd, rd_valid_ff;
  logic [7:0] blank_cycles = 8'h03, consec_periods = 8'h02, cmd_code;
  logic [15:0] p0 = 16'h0, p1 = 16'h0, t_int = 16'h0, t_a = 16'h0, t_b = 16'h0;
  logic [15:0] cmd_wdata, rd_data_ff, got, w;
  logic oc_f, uc_f, oc_r, uc_r, sum_f, ot_f, int_f, xa_f, xb_f, alert_n;
  logic signed [31:0] t;
  logic [7:0] codes[4] = '{`FLM_CMD_PEAK_OC, `FLM_CMD_VALLEY_UC, `FLM_CMD_OVER_TEMP, 8'h50};
  logic [15:0] dflt[4] = '{`FLM_RST_PEAK_OC, `FLM_RST_VALLEY_UC, `FLM_RST_OVER_TEMP, 16'h0000};
  int fails = 0, tests_run = 0;
  always #10 clk = ~clk;
  flm_host_model i_flm_host_model (.clk, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata,
    .rd_data_ff, .rd_valid_ff);
  flm_fault_limit_monitor i_flm_fault_limit_monitor (.clk, .rst_n, .cmd_wr, .cmd_rd, .cmd_code,
    .cmd_wdata, .write_protect, .clear_faults, .period_start, .blank_cycles, .consec_periods,
    .cur_valid, .phase0_current(p0), .phase1_current(p1), .avg_oc_fault, .avg_uc_fault,
    .external_temperature_sensing(ext_on), .temp_valid, .internal_temp(t_int), .ext_temp_a(t_a),
    .ext_temp_b(t_b), .rd_data_ff, .rd_valid_ff, .overcurrent_flag_ff(oc_f),
    .undercurrent_flag_ff(uc_f), .oc_response_ff(oc_r), .uc_response_ff(uc_r),
    .temperature_summary_ff(sum_f), .over_temp_flag_ff(ot_f),
    .internal_sensor_fault_flag_ff(int_f),
    .external_sensor_a_fault_flag_ff(xa_f), .external_sensor_b_fault_flag_ff(xb_f),
    .host_alert_line_n_ff(alert_n));
  // linear word to measurement units of 1/16
  function automatic logic signed [31:0] lin(input logic [15:0] v);
    logic signed [4:0] e;
    logic signed [31:0] m;
    e = v[15:11];
    m = {{21{v[10]}}, v[10:0]};
    lin = (e >= -4) ? (m <<< (e + 4)) : (m >>> (-e - 4));
  endfunction
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one switching period, its sample inside the blanking time or well after it
  task per(input logic [15:0] a, input logic [15:0] b, input logic early);
    @(posedge clk) period_start <= 1'b1;
    @(posedge clk) period_start <= 1'b0;
    repeat (early ? 0 : 5) @(posedge clk);
    cur_valid <= 1'b1;
    p0 <= a;
    p1 <= b;
    @(posedge clk) cur_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task tmp(input logic x, input logic [15:0] i, input logic [15:0] a, input logic [15:0] b);
    @(posedge clk);
    ext_on <= x;
    temp_valid <= 1'b1;
    t_int <= i;
    t_a <= a;
    t_b <= b;
    @(posedge clk) temp_valid <= 1'b0;
    #1;
  endtask
  task clr;
    @(posedge clk) clear_faults <= 1'b1;
    @(posedge clk) clear_faults <= 1'b0;
    #1;
  endtask
  initial begin
    #200000;
    fails++;
    complete_run;
  end
  initial begin
    void'($urandom(32'h6E09));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      i_flm_host_model.rd(codes[k], got, ok);
      chk("read valid", 16'h1, ok);
      chk("reset value", dflt[k], got);
    end
    t = lin(`FLM_RST_OVER_TEMP);
    tmp(1'b1, 16'h0, t[15:0], 16'h0);
    chk("ot at limit", 16'h0, ot_f);
    tmp(1'b1, 16'h0, t[15:0] + 16'h1, 16'h0);
    chk("ot flag", 16'h1, ot_f);
    chk("summary", 16'h1, sum_f);
    chk("sensor a", 16'h1, xa_f);
    chk("alert", 16'h0, alert_n);
    clr;
    chk("ot cleared", 16'h0, ot_f);
    chk("alert released", 16'h1, alert_n);
    tmp(1'b1, 16'h0, 16'h0, t[15:0] + 16'h1);
    chk("sensor b", 16'h1, xb_f);
    clr;
    tmp(1'b0, t[15:0] + 16'h1, 16'h0, 16'h0);
    chk("internal", 16'h1, int_f);
    clr;
    t = lin(`FLM_RST_PEAK_OC);
    // the blanked sample would make the run two periods long if it counted
    per(16'h0, t[15:0] + 16'h1, 1'b1);
    per(16'h0, t[15:0] + 16'h1, 1'b0);
    per(16'h0, t[15:0] + 16'h1, 1'b0);
    chk("oc early", 16'h0, oc_f);
    per(16'h0, 16'h0, 1'b0);
    chk("oc flag", 16'h1, oc_f);
    clr;
    @(posedge clk) consec_periods <= 8'h01;
    t = lin(`FLM_RST_VALLEY_UC);
    per(t[15:0], 16'h0, 1'b0);
    per(t[15:0] - 16'h1, 16'h0, 1'b0);
    chk("uc at limit", 16'h0, uc_f);
    per(16'h0, 16'h0, 1'b0);
    chk("uc flag", 16'h1, uc_f);
    clr;
    @(posedge clk) {avg_oc_fault, avg_uc_fault} <= 2'b11;
    @(posedge clk) {avg_oc_fault, avg_uc_fault} <= 2'b00;
    #1;
    chk("avg flags", 16'h3, {oc_f, uc_f});
    chk("avg responses", 16'h3, {oc_r, uc_r});
    for (int k = 0; k < 3; k++) begin
      w = (k == 2) ? {5'h1D, 1'b0, 10'($urandom % 1000)} : {5'h1B, 11'($urandom)};
      i_flm_host_model.wr(codes[k], w);
      i_flm_host_model.rd(codes[k], got, ok);
      chk("written", w, got);
      @(posedge clk) write_protect <= 1'b1;
      i_flm_host_model.wr(codes[k], ~w);
      i_flm_host_model.rd(codes[k], got, ok);
      chk("protected", w, got);
      @(posedge clk) write_protect <= 1'b0;
    end
    t = lin(w);
    tmp(1'b1, 16'h0, t[15:0], 16'h0);
    chk("random limit", 16'h0, ot_f);
    tmp(1'b1, 16'h0, t[15:0] + 16'h1, 16'h0);
    chk("random over", 16'h1, ot_f);
    // second reset in mid-run: written thresholds, the oc, uc and ot flags and the alert must return home
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("flags after reset", 16'h1, {oc_f, uc_f, ot_f, alert_n});
    for (int k = 0; k < 3; k++) begin
      i_flm_host_model.rd(codes[k], got, ok);
      chk("reset again", dflt[k], got);
    end
    complete_run;
  end
endmodule
